//--- pkg/amf_pkg.sv
// package: constants, register map and types of the amplifier mode/fault control block
package amf_pkg;
	localparam int CLK_NS        = 10;
	localparam int RETRY_MS      = 1500;
	localparam int RETRY_CYC     = RETRY_MS * 1000000 / CLK_NS;
	localparam int RAMP_STEP_NS  = 160;
	localparam int RAMP_CYC      = (RAMP_STEP_NS + CLK_NS - 1) / CLK_NS;
	localparam int STALL_NS      = 2000;
	localparam int STALL_CYC     = (STALL_NS + CLK_NS - 1) / CLK_NS;
	localparam int FRAME_MIN_NS  = 19800;
	localparam int FRAME_MAX_NS  = 23810;
	localparam int FRAME_MIN_CYC = (FRAME_MIN_NS + CLK_NS - 1) / CLK_NS;
	localparam int FRAME_MAX_CYC = FRAME_MAX_NS / CLK_NS;
	localparam int SAMPLE_W      = 16;
	localparam int NSTAT         = 12;

	localparam logic [7:0] A_SOFT_RESET = 8'h01;
	localparam logic [7:0] A_PWR_CTL    = 8'h02;
	localparam logic [7:0] A_MASK0      = 8'h20;
	localparam logic [7:0] A_MASK1      = 8'h21;
	localparam logic [7:0] A_LIVE0      = 8'h22;
	localparam logic [7:0] A_LIVE1      = 8'h23;
	localparam logic [7:0] A_LTCH0      = 8'h24;
	localparam logic [7:0] A_LTCH1      = 8'h25;
	localparam logic [7:0] A_INT_CFG    = 8'h30;
	localparam logic [7:0] A_CLK_CFG    = 8'h3C;

	localparam int SR_BIT       = 0;
	localparam int PWR_VSNS     = 2;
	localparam int PWR_ISNS     = 3;
	localparam int CFG_PU       = 0;
	localparam int CFG_SRC_LSB  = 1;
	localparam int CFG_OT_RETRY = 3;
	localparam int CFG_OC_RETRY = 4;

	localparam logic [1:0]  MODE_ACTIVE = 2'h0;
	localparam logic [1:0]  MODE_MUTE   = 2'h1;
	localparam logic [1:0]  MODE_SWSD   = 2'h2;
	localparam logic [1:0]  MODE_RST    = 2'h2;
	localparam logic [11:0] MASK_RST    = 12'hFFC;
	localparam logic [1:0]  SRC_LIVE    = 2'h0;
	localparam logic [1:0]  SRC_LTCH    = 2'h1;
	localparam logic [1:0]  SRC_RST     = 2'h1;
	localparam logic [1:0]  RATE_RST    = 2'h0;
	localparam logic [11:0] LTCH0_BITS  = 12'h0FF;
	localparam logic [11:0] LTCH1_BITS  = 12'hF00;
	localparam logic [5:0]  GAIN_MAX    = 6'h3F;

	localparam int S_OT  = 0;
	localparam int S_OC  = 1;
	localparam int S_CLK = 2;
	localparam int S_UV  = 10;
	localparam int S_OV  = 11;

	typedef enum logic [2:0] {
		ST_OFF   = 3'b000,
		ST_SWSD  = 3'b001,
		ST_RUN   = 3'b010,
		ST_DOWN  = 3'b011,
		ST_STOP  = 3'b100,
		ST_PWRDN = 3'b101
	} amf_state_e;
endpackage : amf_pkg

//--- verilog/amf_sync2.sv
// module: two-flop synchroniser for pins from outside the clock domain
`timescale 1ns/1ps
`default_nettype none
module amf_sync2 #(
	parameter int W = 1
) (
	input  wire logic         sys_clk_in,
	input  wire logic         rst_in,
	input  wire logic [W-1:0] d_in,
	output logic      [W-1:0] q_out
);
	typedef struct packed {
		logic [W-1:0] s1;
		logic [W-1:0] s2;
	} amf_sync_s;

	amf_sync_s q;
	amf_sync_s n;

	always_comb begin
		n    = q;
		n.s1 = d_in;
		n.s2 = q.s1;
	end

	always_ff @(posedge sys_clk_in) begin
		if (rst_in) begin
			q <= '0;
		end else begin
			q <= n;
		end
	end

	assign q_out = q.s2;
endmodule : amf_sync2
`default_nettype wire

//--- verilog/amf_clk_mon.sv
// module: serial audio clock monitor, ratio, frame rate and stall checks
`timescale 1ns/1ps
`default_nettype none
module amf_clk_mon (
	input  wire logic       sys_clk_in,
	input  wire logic       rst_in,
	input  wire logic       bclk_s_in,
	input  wire logic       frame_sync_s_in,
	input  wire logic [1:0] rate_sel_in,
	output logic            clk_err_out
);
	typedef struct packed {
		logic        bclk_d;
		logic        fs_d;
		logic [9:0]  bits;
		logic [11:0] frame;
		logic [7:0]  idle;
		logic        err;
	} amf_cm_s;

	amf_cm_s    q;
	amf_cm_s    n;
	logic       b_rise;
	logic       f_rise;
	logic [11:0] fmin;
	logic [11:0] fmax;

	// allowed bit clocks per frame, capped by the rate family
	function automatic logic ratio_ok(input logic [9:0] r, input logic [1:0] rate);
		logic ok;
		ok = (r == 10'd64) || (r == 10'd96) || (r == 10'd128);
		if (rate <= 2'd1) begin
			ok = ok || (r == 10'd192) || (r == 10'd256);
		end
		if (rate == 2'd0) begin
			ok = ok || (r == 10'd384) || (r == 10'd512);
		end
		return ok && (rate != 2'd3);
	endfunction : ratio_ok

	always_comb begin
		n        = q;
		fmin     = 12'(amf_pkg::FRAME_MIN_CYC) >> rate_sel_in;
		fmax     = 12'(amf_pkg::FRAME_MAX_CYC) >> rate_sel_in;
		b_rise   = bclk_s_in && !q.bclk_d;
		f_rise   = frame_sync_s_in && !q.fs_d;
		n.bclk_d = bclk_s_in;
		n.fs_d   = frame_sync_s_in;
		if (b_rise) begin
			n.idle = '0;
		end else if (q.idle != '1) begin
			n.idle = q.idle + 8'd1;
		end
		if (q.frame != '1) begin
			n.frame = q.frame + 12'd1;
		end
		if (b_rise && q.bits != '1) begin
			n.bits = q.bits + 10'd1;
		end
		if (f_rise) begin
			n.err   = !ratio_ok(q.bits, rate_sel_in) || q.frame < fmin || q.frame > fmax;
			n.frame = '0;
			n.bits  = {9'd0, b_rise};
		end
		// stopped bit clock or frame sync
		if (q.idle >= 8'(amf_pkg::STALL_CYC) || q.frame > fmax) begin
			n.err = 1'b1;
		end
	end

	always_ff @(posedge sys_clk_in) begin
		if (rst_in) begin
			q     <= '0;
			q.err <= 1'b1;
		end else begin
			q <= n;
		end
	end

	assign clk_err_out = q.err;
endmodule : amf_clk_mon
`default_nettype wire

//--- verilog/amf_ctrl.sv
// module: amplifier mode sequencing, fault handling, status and interrupt pin
`timescale 1ns/1ps
`default_nettype none
module amf_ctrl #(
	parameter int RETRY_CYCLES = amf_pkg::RETRY_CYC
) (
	input  wire logic                          sys_clk_in,
	input  wire logic                          rst_in,
	input  wire logic [7:0]                    reg_addr_in,
	input  wire logic [7:0]                    reg_wdata_in,
	input  wire logic                          reg_wr_in,
	input  wire logic                          reg_rd_in,
	output logic      [7:0]                    reg_rdata_out,
	input  wire logic                          shutdown_n_pin_in,
	input  wire logic                          mode_pin_in,
	input  wire logic                          serial_bit_clock_in,
	input  wire logic                          frame_sync_in,
	input  wire logic                          overtemp_in,
	input  wire logic                          overcurrent_in,
	input  wire logic                          battery_low_lockout_in,
	input  wire logic                          battery_high_lockout_in,
	input  wire logic                          limiter_active_in,
	input  wire logic                          below_inflection_in,
	input  wire logic                          max_atten_in,
	input  wire logic                          inf_hold_in,
	input  wire logic                          limiter_mute_in,
	input  wire logic                          pdm_clock_error_in,
	input  wire logic                          brownout_in,
	input  wire logic [amf_pkg::SAMPLE_W-1:0]  isns_sample_in,
	input  wire logic [amf_pkg::SAMPLE_W-1:0]  vsns_sample_in,
	output logic      [amf_pkg::SAMPLE_W-1:0]  isns_sample_out,
	output logic      [amf_pkg::SAMPLE_W-1:0]  vsns_sample_out,
	output logic                               current_sense_powerdown_out,
	output logic                               voltage_sense_powerdown_out,
	output logic                               amp_switching_out,
	output logic                               analog_power_out,
	output logic                               digital_power_out,
	output logic      [5:0]                    volume_out,
	output logic                               interface_mode_out,
	output logic                               irq_n_pin_out,
	output logic                               irq_n_pin_oe_n_out,
	output logic                               irq_pullup_enable_out
);
	typedef struct packed {
		amf_pkg::amf_state_e            st;
		logic [5:0]                     gain;
		logic [4:0]                     rtick;
		logic [1:0]                     mode;
		logic                           voltage_sense_powerdown;
		logic                           current_sense_powerdown;
		logic [11:0]                    mask;
		logic [11:0]                    ltch;
		logic                           pu;
		logic [1:0]                     src;
		logic                           ot_retry;
		logic                           oc_retry;
		logic [1:0]                     rate;
		logic                           ifmode;
		logic                           lock;
		logic                           therm_hold;
		logic [27:0]                    rtimer;
		logic [7:0]                     rdata;
		logic                           irq;
		logic                           sw;
		logic                           ana;
		logic                           dig;
		logic [amf_pkg::SAMPLE_W-1:0]   isamp;
		logic [amf_pkg::SAMPLE_W-1:0]   vsamp;
	} amf_ctrl_s;

	amf_ctrl_s   q;
	amf_ctrl_s   n;
	logic [14:0] pins_s;
	logic        clk_err;
	logic [11:0] live;
	logic [11:0] clr;
	logic [11:0] irq_sel;
	logic [7:0]  rd_val;
	logic [5:0]  target;
	logic        hw_off;
	logic        mode_s;
	logic        bus_en;
	logic        ramp_tick;
	logic        host_sd;
	logic        therm;
	logic        lockout;
	logic        fast;

	// every software-visible field back to its default
	function automatic amf_ctrl_s cfg_default(input amf_ctrl_s s);
		amf_ctrl_s r;
		r          = s;
		r.mode     = amf_pkg::MODE_RST;
		r.voltage_sense_powerdown  = 1'b0;
		r.current_sense_powerdown  = 1'b0;
		r.mask     = amf_pkg::MASK_RST;
		r.ltch     = '0;
		r.pu       = 1'b0;
		r.src      = amf_pkg::SRC_RST;
		r.ot_retry = 1'b0;
		r.oc_retry = 1'b0;
		r.rate     = amf_pkg::RATE_RST;
		return r;
	endfunction : cfg_default

	amf_sync2 #(
		.W(15)
	) u_sync (
		.sys_clk_in(sys_clk_in),
		.rst_in    (rst_in),
		.d_in      ({shutdown_n_pin_in, mode_pin_in, serial_bit_clock_in, frame_sync_in,
		             battery_high_lockout_in, battery_low_lockout_in, brownout_in,
		             pdm_clock_error_in, limiter_mute_in, inf_hold_in, max_atten_in,
		             below_inflection_in, limiter_active_in, overcurrent_in, overtemp_in}),
		.q_out     (pins_s)
	);

	amf_clk_mon u_cmon (
		.sys_clk_in (sys_clk_in),
		.rst_in     (rst_in),
		.bclk_s_in  (pins_s[12]),
		.frame_sync_s_in (pins_s[11]),
		.rate_sel_in(q.rate),
		.clk_err_out(clk_err)
	);

	assign hw_off = !pins_s[14];
	assign mode_s = pins_s[13];
	assign live   = {pins_s[10:2], clk_err, pins_s[1:0]};

	always_comb begin
		case (reg_addr_in)
			amf_pkg::A_PWR_CTL: rd_val = {4'h0, q.current_sense_powerdown, q.voltage_sense_powerdown, q.mode};
			amf_pkg::A_MASK0:   rd_val = q.mask[7:0];
			amf_pkg::A_MASK1:   rd_val = {4'h0, q.mask[11:8]};
			amf_pkg::A_LIVE0:   rd_val = live[7:0];
			amf_pkg::A_LIVE1:   rd_val = {4'h0, live[11:8]};
			amf_pkg::A_LTCH0:   rd_val = q.ltch[7:0];
			amf_pkg::A_LTCH1:   rd_val = {4'h0, q.ltch[11:8]};
			amf_pkg::A_INT_CFG: rd_val = {3'h0, q.oc_retry, q.ot_retry, q.src, q.pu};
			amf_pkg::A_CLK_CFG: rd_val = {6'h00, q.rate};
			default:            rd_val = 8'h00;
		endcase
	end

	always_comb begin
		n         = q;
		bus_en    = !hw_off && q.st != amf_pkg::ST_OFF;
		ramp_tick = (q.rtick == '0);
		n.rtick   = ramp_tick ? 5'(amf_pkg::RAMP_CYC - 1) : q.rtick - 5'd1;
		host_sd   = hw_off || q.mode[1];
		target    = (q.mode == amf_pkg::MODE_MUTE) ? 6'h00 : amf_pkg::GAIN_MAX;

		// thermal/current faults: hold-off timer runs through shutdowns
		therm = live[amf_pkg::S_OT] || live[amf_pkg::S_OC];
		if (therm) begin
			n.rtimer = 28'(RETRY_CYCLES);
		end else if (q.rtimer != '0) begin
			n.rtimer = q.rtimer - 28'd1;
		end
		if ((live[amf_pkg::S_OT] && !q.ot_retry) || (live[amf_pkg::S_OC] && !q.oc_retry)) begin
			n.therm_hold = 1'b1;
		end else if (host_sd) begin
			n.therm_hold = 1'b0;
		end
		lockout = live[amf_pkg::S_UV] || live[amf_pkg::S_OV];
		if (lockout) begin
			n.lock = 1'b1;
		end else if (host_sd) begin
			n.lock = 1'b0;
		end
		fast = clk_err || lockout || q.lock || therm || q.therm_hold || q.rtimer != '0;

		case (q.st)
			amf_pkg::ST_RUN: begin
				if (fast) begin
					n.gain = '0;
					n.st   = amf_pkg::ST_STOP;
				end else if (host_sd) begin
					n.st = amf_pkg::ST_DOWN;
				end else if (ramp_tick && q.gain < target) begin
					n.gain = q.gain + 6'd1;
				end else if (ramp_tick && q.gain > target) begin
					n.gain = q.gain - 6'd1;
				end
			end
			amf_pkg::ST_DOWN: begin
				if (fast) begin
					n.gain = '0;
					n.st   = amf_pkg::ST_STOP;
				end else if (q.gain == '0) begin
					n.st = amf_pkg::ST_STOP;
				end else if (ramp_tick) begin
					n.gain = q.gain - 6'd1;
				end
			end
			amf_pkg::ST_STOP: begin
				n.st = hw_off ? amf_pkg::ST_PWRDN : amf_pkg::ST_SWSD;
			end
			amf_pkg::ST_PWRDN: begin
				n.st = amf_pkg::ST_OFF;
			end
			amf_pkg::ST_OFF: begin
				if (!hw_off) begin
					n.ifmode = mode_s;
					n.st     = amf_pkg::ST_SWSD;
				end
			end
			amf_pkg::ST_SWSD: begin
				if (hw_off) begin
					n.st = amf_pkg::ST_PWRDN;
				end else if (!fast && !host_sd) begin
					n.gain = '0;
					n.st   = amf_pkg::ST_RUN;
				end
			end
			default: begin
				n.st = amf_pkg::ST_OFF;
			end
		endcase

		if (reg_wr_in && bus_en) begin
			case (reg_addr_in)
				amf_pkg::A_PWR_CTL: begin
					n.mode    = reg_wdata_in[1:0];
					n.voltage_sense_powerdown = reg_wdata_in[amf_pkg::PWR_VSNS];
					n.current_sense_powerdown = reg_wdata_in[amf_pkg::PWR_ISNS];
				end
				amf_pkg::A_MASK0:   n.mask[7:0]  = reg_wdata_in;
				amf_pkg::A_MASK1:   n.mask[11:8] = reg_wdata_in[3:0];
				amf_pkg::A_INT_CFG: begin
					n.pu       = reg_wdata_in[amf_pkg::CFG_PU];
					n.src      = reg_wdata_in[amf_pkg::CFG_SRC_LSB +: 2];
					n.ot_retry = reg_wdata_in[amf_pkg::CFG_OT_RETRY];
					n.oc_retry = reg_wdata_in[amf_pkg::CFG_OC_RETRY];
				end
				amf_pkg::A_CLK_CFG: n.rate = reg_wdata_in[1:0];
				default: ;
			endcase
		end

		clr = '0;
		if (reg_rd_in && bus_en && reg_addr_in == amf_pkg::A_LTCH0) begin
			clr = amf_pkg::LTCH0_BITS;
		end
		if (reg_rd_in && bus_en && reg_addr_in == amf_pkg::A_LTCH1) begin
			clr = amf_pkg::LTCH1_BITS;
		end
		n.ltch  = (q.ltch & ~clr) | live;
		n.rdata = (reg_rd_in && bus_en) ? rd_val : 8'h00;

		if (reg_wr_in && bus_en && reg_addr_in == amf_pkg::A_SOFT_RESET
		    && reg_wdata_in[amf_pkg::SR_BIT]) begin
			n = cfg_default(n);
		end
		if (n.st == amf_pkg::ST_OFF) begin
			n = cfg_default(n);
		end

		case (q.src)
			amf_pkg::SRC_LIVE: irq_sel = live;
			amf_pkg::SRC_LTCH: irq_sel = q.ltch;
			default:           irq_sel = '0;
		endcase
		n.irq   = |(irq_sel & ~q.mask);
		n.sw    = n.st == amf_pkg::ST_RUN || n.st == amf_pkg::ST_DOWN;
		n.ana   = n.sw || (n.st == amf_pkg::ST_STOP && hw_off);
		n.dig   = n.st != amf_pkg::ST_OFF && n.st != amf_pkg::ST_PWRDN;
		n.isamp = (n.current_sense_powerdown || n.st != amf_pkg::ST_RUN) ? '0 : isns_sample_in;
		n.vsamp = (n.voltage_sense_powerdown || n.st != amf_pkg::ST_RUN) ? '0 : vsns_sample_in;
	end

	always_ff @(posedge sys_clk_in) begin
		if (rst_in) begin
			q <= cfg_default('0);
		end else begin
			q <= n;
		end
	end

	assign reg_rdata_out               = q.rdata;
	assign isns_sample_out             = q.isamp;
	assign vsns_sample_out             = q.vsamp;
	assign current_sense_powerdown_out = q.current_sense_powerdown;
	assign voltage_sense_powerdown_out = q.voltage_sense_powerdown;
	assign amp_switching_out           = q.sw;
	assign analog_power_out            = q.ana;
	assign digital_power_out           = q.dig;
	assign volume_out                  = q.gain;
	assign interface_mode_out          = q.ifmode;
	assign irq_n_pin_out               = 1'b0;
	assign irq_n_pin_oe_n_out          = !q.irq;
	assign irq_pullup_enable_out       = q.pu;

	default clocking cb @(posedge sys_clk_in); endclocking
	default disable iff (rst_in);

	sequence s_stop_hw;
		q.st == amf_pkg::ST_STOP && hw_off;
	endsequence
	sequence s_power_off;
		!analog_power_out && !digital_power_out ##1 q.st == amf_pkg::ST_OFF;
	endsequence

	a_sense_null:
		assert property (q.current_sense_powerdown |-> isns_sample_out == '0 && current_sense_powerdown_out)
		else $error("current sense not nulled");
	a_clk_err_stop:
		assert property (clk_err && q.st == amf_pkg::ST_RUN |=> !amp_switching_out
			&& volume_out == 6'h00)
		else $error("clock error did not stop playback");
	a_off_silent:
		assert property (q.st == amf_pkg::ST_OFF && reg_rd_in |=> reg_rdata_out == 8'h00)
		else $error("port answered in hardware shutdown");
	a_hw_sd_order:
		assert property (s_stop_hw |-> !amp_switching_out && analog_power_out ##1 s_power_off)
		else $error("shutdown steps out of order");
	a_mode_pin_take:
		assert property (q.st == amf_pkg::ST_OFF && !hw_off |=> interface_mode_out == $past(mode_s))
		else $error("mode pin not sampled at release");
	a_swsd_quiet:
		assert property (q.st == amf_pkg::ST_SWSD && q.mode == amf_pkg::MODE_SWSD
			|=> !amp_switching_out)
		else $error("switching in software shutdown");
	a_mute_silent:
		assert property (q.st == amf_pkg::ST_RUN && q.mode == amf_pkg::MODE_MUTE && !fast
			&& q.gain == 6'h00 |=> amp_switching_out && volume_out == 6'h00)
		else $error("mute not silent");
	a_active_start:
		assert property (q.st == amf_pkg::ST_SWSD && q.mode == amf_pkg::MODE_ACTIVE && !fast
			&& !hw_off |=> amp_switching_out)
		else $error("active mode did not start");
	a_soft_reset_def:
		assert property (reg_wr_in && bus_en && reg_addr_in == amf_pkg::A_SOFT_RESET
			&& reg_wdata_in[0] |=> q.mode == amf_pkg::MODE_RST && q.mask == amf_pkg::MASK_RST)
		else $error("soft reset left a register changed");
	a_lockout_pwr:
		assert property (lockout |=> !analog_power_out ##1 !amp_switching_out)
		else $error("lockout kept analog powered");
	a_ltch_clear:
		assert property (reg_rd_in && bus_en && reg_addr_in == amf_pkg::A_LTCH0
			&& n.st != amf_pkg::ST_OFF |=> q.ltch[7:0] == $past(live[7:0]))
		else $error("latched status not cleared by read");
	a_retry_hold:
		assert property (q.rtimer != '0 |=> !amp_switching_out)
		else $error("restart inside retry hold-off");
	a_irq_live_pin:
		assert property (q.src == amf_pkg::SRC_LIVE && |(live & ~q.mask) |=> !irq_n_pin_oe_n_out)
		else $error("unmasked live condition not on pin");
endmodule : amf_ctrl
`default_nettype wire

//--- verif/amf_tdm_host.sv
// tdm host model: bit clock and frame sync source
`timescale 1ns/1ps
`default_nettype none
module amf_tdm_host #(
	parameter int BITS = 64
) (
	input  wire logic run_in,
	output logic      bclk_out,
	output logic      frame_sync_out
);
	int n;
	initial begin
		bclk_out = 1'b0;
		frame_sync_out = 1'b0;
		n = 0;
		forever begin
			if (run_in) begin
				#40 bclk_out = 1'b1;
				frame_sync_out = (n == 0);
				n = (n + 1) % BITS;
				#40 bclk_out = 1'b0;
			end else begin
				// clocks stand still while stopped
				#40;
			end
		end
	end
endmodule : amf_tdm_host
`default_nettype wire

//--- verif/amp_mode_fault_irq_ctrl_test.sv
// testbench: modes, faults, status and interrupt pin of amf_ctrl
`timescale 1ns/1ps
`default_nettype none
module amp_mode_fault_irq_ctrl_test;
	typedef struct {bit w; logic [7:0] a; logic [7:0] d;} amf_row_s;
	logic        clk, rst, wr, rd, sdn, mpin, run, ot, oc, uv;
	logic [7:0]  addr, wdata, rdata;
	logic [4:0]  lim;
	logic [1:0]  misc;
	logic [15:0] isin, vsin, isout, vsout;
	logic        ipd, vpd, sw, apw, dpw, imode, irqv, irqoe, pu, bclk, fs;
	logic [5:0]  vol;
	int          failures, samples_checked, ticks;
	wire         irq_w = irqoe ? 1'b1 : irqv;
	amf_row_s    rows[18] = '{'{0, 8'h01, 8'h00}, '{0, 8'h02, 8'h02}, '{0, 8'h20, 8'hFC},
		'{0, 8'h21, 8'h0F}, '{0, 8'h30, 8'h02}, '{0, 8'h3C, 8'h00}, '{0, 8'h77, 8'h00},
		'{1, 8'h77, 8'h5A}, '{0, 8'h77, 8'h00}, '{1, 8'h21, 8'h03}, '{0, 8'h21, 8'h03},
		'{1, 8'h3C, 8'h02}, '{0, 8'h3C, 8'h02}, '{1, 8'h30, 8'h09}, '{0, 8'h30, 8'h09},
		'{1, 8'h20, 8'h00}, '{0, 8'h20, 8'h00}, '{0, 8'h24, 8'h04}};

	amf_tdm_host amf_tdm_host_inst (.run_in(run), .bclk_out(bclk), .frame_sync_out(fs));
	amf_ctrl #(.RETRY_CYCLES(200)) amf_ctrl_inst (.sys_clk_in(clk), .rst_in(rst),
		.reg_addr_in(addr), .reg_wdata_in(wdata), .reg_wr_in(wr), .reg_rd_in(rd),
		.reg_rdata_out(rdata), .shutdown_n_pin_in(sdn), .mode_pin_in(mpin),
		.serial_bit_clock_in(bclk), .frame_sync_in(fs), .overtemp_in(ot),
		.overcurrent_in(oc), .battery_low_lockout_in(uv), .battery_high_lockout_in(1'b0),
		.limiter_active_in(lim[0]), .below_inflection_in(lim[1]), .max_atten_in(lim[2]),
		.inf_hold_in(lim[3]), .limiter_mute_in(lim[4]), .pdm_clock_error_in(misc[0]),
		.brownout_in(misc[1]), .isns_sample_in(isin), .vsns_sample_in(vsin),
		.isns_sample_out(isout), .vsns_sample_out(vsout),
		.current_sense_powerdown_out(ipd), .voltage_sense_powerdown_out(vpd),
		.amp_switching_out(sw), .analog_power_out(apw), .digital_power_out(dpw),
		.volume_out(vol), .interface_mode_out(imode), .irq_n_pin_out(irqv),
		.irq_n_pin_oe_n_out(irqoe), .irq_pullup_enable_out(pu));

	task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
		samples_checked++;
		if (g !== e) begin
			failures++;
			$display("FAIL %s expected %h seen %h", nm, e, g);
		end
	endtask : chk

	task automatic cyc(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask : cyc

	task automatic wrr(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk);
		addr <= a;
		wdata <= d;
		wr <= 1'b1;
		@(posedge clk);
		wr <= 1'b0;
	endtask : wrr

	task automatic rdc(input logic [7:0] a, input logic [7:0] e, input string nm);
		@(posedge clk);
		addr <= a;
		rd <= 1'b1;
		@(posedge clk);
		rd <= 1'b0;
		#1;
		chk(nm, {8'h00, e}, {8'h00, rdata});
	endtask : rdc

	task automatic end_of_test;
		if (failures == 0 && samples_checked > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask : end_of_test

	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end

	always @(posedge clk) begin
		ticks <= ticks + 1;
		if (ticks == 40000) begin
			failures++;
			end_of_test();
		end
	end

	initial begin
		{wr, rd, sdn, mpin, run, ot, oc, uv, lim, misc} = '0;
		{addr, wdata, isin, vsin, failures, samples_checked, ticks} = '0;
		rst = 1'b1;
		cyc(8);
		chk("rst oe_n", 16'h1, irqoe);
		chk("rst sw", 16'h0, sw);
		chk("rst dig", 16'h0, dpw);
		chk("rst vol", 16'h0, vol);
		rst <= 1'b0;
		sdn <= 1'b1;
		cyc(6);
		foreach (rows[i]) begin
			if (rows[i].w) wrr(rows[i].a, rows[i].d);
			else rdc(rows[i].a, rows[i].d, "reg");
		end
		cyc(5);
		chk("irq clk", 16'h0, irq_w);
		chk("pullup", 16'h1, pu);
		wrr(8'h20, 8'h04);
		cyc(3);
		chk("irq masked", 16'h1, irq_w);
		run <= 1'b1;
		cyc(1600);
		rdc(8'h22, 8'h00, "live0");
		rdc(8'h24, 8'h04, "ltch0");
		rdc(8'h24, 8'h00, "ltch0 clr");
		lim <= 5'h1F;
		misc <= 2'h3;
		cyc(5);
		rdc(8'h22, 8'hF8, "live0 lim");
		rdc(8'h23, 8'h03, "live1");
		chk("irq lim", 16'h0, irq_w);
		lim <= 5'h00;
		misc <= 2'h0;
		cyc(5);
		chk("irq live", 16'h1, irq_w);
		wrr(8'h30, 8'h0B);
		cyc(3);
		chk("irq ltch", 16'h0, irq_w);
		rdc(8'h24, 8'hF8, "ltch0 lim");
		rdc(8'h25, 8'h03, "ltch1");
		cyc(3);
		chk("irq cleared", 16'h1, irq_w);
		wrr(8'h30, 8'h09);
		isin <= 16'h1234;
		vsin <= 16'h5678;
		wrr(8'h02, 8'h08);
		cyc(1200);
		chk("vol", 16'h3F, vol);
		chk("sw", 16'h1, sw);
		chk("isns", 16'h0, isout);
		chk("ipd", 16'h1, ipd);
		chk("vsns", 16'h5678, vsout);
		wrr(8'h02, 8'h09);
		cyc(1200);
		chk("vol mute", 16'h0, vol);
		chk("sw mute", 16'h1, sw);
		wrr(8'h02, 8'h00);
		cyc(1200);
		chk("vol back", 16'h3F, vol);
		chk("isns on", 16'h1234, isout);
		run <= 1'b0;
		cyc(300);
		chk("sw stall", 16'h0, sw);
		run <= 1'b1;
		cyc(2800);
		chk("vol resume", 16'h3F, vol);
		ot <= 1'b1;
		cyc(10);
		chk("sw ot", 16'h0, sw);
		chk("irq ot", 16'h0, irq_w);
		rdc(8'h22, 8'h01, "live0 ot");
		ot <= 1'b0;
		cyc(150);
		chk("sw holdoff", 16'h0, sw);
		cyc(1400);
		chk("vol retry", 16'h3F, vol);
		oc <= 1'b1;
		cyc(10);
		oc <= 1'b0;
		wrr(8'h02, 8'h02);
		wrr(8'h02, 8'h00);
		cyc(100);
		chk("sw oc", 16'h0, sw);
		cyc(1400);
		chk("vol oc", 16'h3F, vol);
		uv <= 1'b1;
		cyc(6);
		chk("analog", 16'h0, apw);
		rdc(8'h23, 8'h04, "live1 uv");
		uv <= 1'b0;
		cyc(1200);
		chk("sw uv", 16'h0, sw);
		wrr(8'h02, 8'h02);
		wrr(8'h02, 8'h00);
		cyc(1200);
		chk("vol uv", 16'h3F, vol);
		sdn <= 1'b0;
		cyc(20);
		chk("sw ramp", 16'h1, sw);
		chk("dig ramp", 16'h1, dpw);
		cyc(1200);
		chk("dig off", 16'h0, dpw);
		chk("sw off", 16'h0, sw);
		rdc(8'h20, 8'h00, "mask0 off");
		mpin <= 1'b1;
		sdn <= 1'b1;
		cyc(6);
		chk("imode", 16'h1, imode);
		rdc(8'h20, 8'hFC, "mask0 rst");
		wrr(8'h20, 8'h55);
		wrr(8'h01, 8'h01);
		rdc(8'h20, 8'hFC, "mask0 sr");
		rdc(8'h01, 8'h00, "sreset");
		wrr(8'h02, 8'h04);
		cyc(2);
		chk("vpd", 16'h1, vpd);
		chk("voltage_sense_powerdown", 16'h0, vsout);
		rst <= 1'b1;
		cyc(4);
		chk("mid rst oe_n", 16'h1, irqoe);
		chk("mid rst vpd", 16'h0, vpd);
		rst <= 1'b0;
		cyc(6);
		rdc(8'h02, 8'h02, "pwr rst");
		chk("irq drive level", 16'h0, irqv);
		end_of_test();
	end
endmodule : amp_mode_fault_irq_ctrl_test
`default_nettype wire
